// >>> sim/scp_peer.sv
// Peer serial transceiver on the data and clock pins
`timescale 1ns/100ps
module scp_peer (
  input  wire logic       txd_out,
  input  wire logic       sck_out,
  output logic            rxd_in,
  output logic            sck_in,
  output logic      [7:0] got,
  output logic            got_v
);
  initial begin
    rxd_in = 1'h1;
    sck_in = 1'h1;
    got    = 8'h00;
    got_v  = 1'h0;
  end
  // Async frame, start bit in f[0], 64 ns bits, line back to pulled-up mark
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd_in = f[i];
      #64;
    end
    rxd_in = 1'h1;
  endtask
  // Holds the line at a level, low for a break
  task automatic brk(input logic lv);
    rxd_in = lv;
  endtask
  // External clock frame, 80 ns period, clock idles high between frames
  task automatic xfer(input logic [7:0] d);
    #24;
    for (int i = 0; i < 8; i++) begin
      sck_in = 1'h0;
      rxd_in = d[i];
      #40;
      sck_in = 1'h1;
      got[i] = txd_out;
      #40;
    end
    rxd_in = 1'h1;
    got_v  = !got_v;
  endtask
  // Async frame from the block, sampled mid-bit, returns in the stop bit
  task automatic rcv;
    @(negedge txd_out);
    #32;
    for (int i = 0; i < 8; i++) begin
      #64;
      got[i] = txd_out;
    end
    #64;
    got_v = !got_v;
  endtask
  // Internal clock frame, data set on falling clock, sampled on rising
  task automatic ixfer(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge sck_out);
      rxd_in = d[i];
      @(posedge sck_out);
      got[i] = txd_out;
    end
    rxd_in = 1'h1;
    got_v  = !got_v;
  endtask
endmodule

// >>> sim/scp_serial_port_monitor.sv
// Checker for the serial port bus and pins
`timescale 1ns/100ps
module scp_serial_port_monitor (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        rxd_in,
  input wire logic        txd_out,
  input wire logic        txd_oe_b,
  input wire logic        sck_out,
  input wire logic        sck_oe_b,
  input wire logic        rx_error_irq,
  input wire logic        rx_dma_req,
  input wire logic        tx_dma_req
);
  // ****
  // Bus phase tracking
  // ****
  logic        wr_ctl;
  logic        cw_v;
  logic        rd_st;
  logic        te_q;
  logic        te_q2;
  logic        rxd_p;
  logic [10:0] cw;
  logic [2:0]  st;
  wire         ap = hsel & htrans[1] & hready;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ctl <= 1'h0;
      cw_v   <= 1'h0;
      rd_st  <= 1'h0;
      te_q   <= 1'h0;
      te_q2  <= 1'h0;
      rxd_p  <= 1'h1;
      cw     <= 11'h000;
      st     <= 3'h0;
    end else begin
      wr_ctl <= ap & hwrite & (haddr[7:0] == 8'h00);
      rd_st  <= ap & !hwrite & (haddr[7:0] == 8'h08);
      cw_v   <= wr_ctl;
      cw     <= wr_ctl ? hwdata[10:0] : cw;
      te_q   <= cw_v ? cw[0] : te_q;
      te_q2  <= te_q;
      rxd_p  <= rxd_in;
      st     <= (rxd_in != rxd_p) ? 3'h0 : ((st == 3'h7) ? st : st + 3'h1);
    end
  end
  // ****
  // Assertions
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  bus_okay_a : assert property (
    hreadyout && !hresp) else $error("bus not ready or not okay");
  pin_back_a : assert property (
    cw_v && !cw[0] |-> ##[1:3] (txd_out == cw[8] && txd_oe_b == !cw[9]))
    else $error("txd pin not under port control");
  te_clr_empty_a : assert property (
    rd_st && !cw_v && !te_q && !te_q2 |-> hrdata[0]) else $error("tx empty not set");
  err_irq_a : assert property (
    rd_st |-> $past(rx_error_irq) == (|hrdata[4:2])) else $error("error request wrong");
  err_hold_tx_a : assert property (
    rx_error_irq && $past(rx_error_irq) |-> !$fell(sck_out)) else $error("frame started");
  re_keep_err_a : assert property (
    cw_v && !cw[1] && rx_error_irq |=> rx_error_irq [*2]) else $error("error flags lost");
  live_rxd_a : assert property (
    rd_st && st >= 3'h5 |-> hrdata[6] == rxd_p) else $error("live rxd bit wrong");
  ovr_full_a : assert property (
    rd_st && hrdata[2] |-> hrdata[1]) else $error("overrun without rx full");
  full_req_a : assert property (
    rd_st |-> $past(rx_dma_req) == hrdata[1]) else $error("rx request wrong");
  tx_req_a : assert property (
    rd_st |-> $past(tx_dma_req) == (hrdata[0] && te_q)) else $error("tx request wrong");
  sck_pin_a : assert property (
    cw_v |-> sck_oe_b == !(cw[2] && !cw[3])) else $error("sck enable wrong");
endmodule

bind scp_serial_port scp_serial_port_monitor mon (.clk, .rst_b, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rxd_in, .txd_out, .txd_oe_b,
  .sck_out, .sck_oe_b, .rx_error_irq, .rx_dma_req, .tx_dma_req);

// >>> sim/scp_serial_port_tb_top.sv
// Testbench for the serial port block
`timescale 1ns/100ps
module scp_serial_port_tb_top;
  logic        clk = 1'h0;
  logic        rst_b = 1'h0;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, rxd_in, sck_in, txd_out, txd_oe_b, sck_out, got_v;
  logic [7:0]  got;
  logic [7:0]  r;
  logic        rd_dp = 1'h0;
  logic [31:0] lf = 32'h26912635;
  logic [63:0] ex;
  logic [63:0] exq[$];
  logic [7:0]  txq[$];
  int          error_cnt = 0;
  int          n_checks = 0;
  always #2 clk = !clk;
  scp_serial_port uut (.clk, .rst_b, .ce(1'h1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rxd_in,
    .sck_in, .txd_out, .txd_oe_b, .sck_out, .sck_oe_b(), .rx_error_irq(), .rx_dma_req(),
    .tx_dma_req());
  scp_peer peer (.txd_out, .sck_out, .rxd_in, .sck_in, .got, .got_v);
  // ****
  // Tasks
  // ****
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp  <= !w;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    rd_dp  <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    exq.push_back({m, e});
    bus(a, 1'h0, 32'h0);
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****
  // Result watchers
  // ****
  always @(negedge clk) begin
    if (rd_dp) begin
      ex = exq.pop_front();
      chk(hrdata & ex[63:32], ex[31:0]);
    end
  end
  always @(got_v) begin
    if (txq.size() != 0) chk({24'h0, got}, {24'h0, txq.pop_front()});
  end
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    rd(8'h08, 32'h7F, 32'h61);
    rd(8'h14, 32'hFFFFFFFF, 32'h0);
    bus(8'h18, 1'h1, 32'hFF);
    bus(8'h04, 1'h1, 32'h0);
    bus(8'h00, 1'h1, 32'h2);
    rd(8'h00, 32'h7FF, 32'h2);
    lf = nx(lf);
    peer.send({3'h7, lf[7:0], 1'h0}, 10);
    rd(8'h08, 32'h1E, 32'h2);
    rd(8'h10, 32'hFF, {24'h0, lf[7:0]});
    peer.send({3'h7, lf[15:8], 1'h0}, 10);
    rd(8'h08, 32'h1E, 32'h6);
    rd(8'h10, 32'hFF, {24'h0, lf[7:0]});
    bus(8'h08, 1'h1, 32'h0);
    bus(8'h00, 1'h1, 32'h22);
    peer.send({2'h3, ~^lf[23:16], lf[23:16], 1'h0}, 11);
    rd(8'h08, 32'h1E, 32'h10);
    rd(8'h10, 32'hFF, {24'h0, lf[23:16]});
    bus(8'h08, 1'h1, 32'h0);
    bus(8'h00, 1'h1, 32'h2);
    peer.brk(1'h0);
    #800;
    rd(8'h08, 32'h4A, 32'h8);
    bus(8'h08, 1'h1, 32'h0);
    #800;
    rd(8'h08, 32'h8, 32'h8);
    peer.brk(1'h1);
    #800;
    bus(8'h08, 1'h1, 32'h0);
    bus(8'h00, 1'h1, 32'h401);
    lf = nx(lf);
    txq.push_back(lf[7:0]);
    bus(8'h0C, 1'h1, {24'h0, lf[7:0]});
    peer.rcv();
    #40;
    rd(8'h08, 32'h21, 32'h21);
    bus(8'h00, 1'h1, 32'h40F);
    lf = nx(lf);
    r = lf[31:24];
    bus(8'h0C, 1'h1, {24'h0, lf[7:0]});
    txq.push_back(lf[7:0]);
    bus(8'h0C, 1'h1, {24'h0, lf[15:8]});
    bus(8'h0C, 1'h1, {24'h0, lf[23:16]});
    rd(8'h08, 32'h1, 32'h0);
    txq.push_back(lf[23:16]);
    peer.xfer(r);
    rd(8'h08, 32'h1F, 32'h3);
    rd(8'h10, 32'hFF, {24'h0, r});
    lf = nx(lf);
    peer.xfer(lf[7:0]);
    rd(8'h08, 32'h1E, 32'h6);
    rd(8'h10, 32'hFF, {24'h0, r});
    bus(8'h00, 1'h1, 32'h40D);
    rd(8'h08, 32'h1C, 32'h4);
    bus(8'h04, 1'h1, 32'h7);
    bus(8'h00, 1'h1, 32'h407);
    lf = nx(lf);
    bus(8'h0C, 1'h1, {24'h0, lf[7:0]});
    rd(8'h08, 32'h1, 32'h0);
    txq.push_back(lf[7:0]);
    bus(8'h08, 1'h1, 32'h0);
    peer.ixfer(lf[15:8]);
    #20;
    rd(8'h08, 32'h1E, 32'h2);
    rd(8'h10, 32'hFF, {24'h0, lf[15:8]});
    bus(8'h00, 1'h1, 32'h300);
    rd(8'h08, 32'h1, 32'h1);
    bus(8'h00, 1'h1, 32'h200);
    bus(8'h08, 1'h1, 32'h0);
    rd(8'h08, 32'h1E, 32'h0);
    conclude();
  end
endmodule

// >>> verilog/scp_pkg.sv
// Constants and types for the serial port block
package scp_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] BAUD_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] TXD_OFS  = 8'h0C;
  localparam logic [7:0] RXD_OFS  = 8'h10;

  localparam logic [2:0] RI_CTRL = 3'h0;
  localparam logic [2:0] RI_BAUD = 3'h1;
  localparam logic [2:0] RI_STAT = 3'h2;
  localparam logic [2:0] RI_TXD  = 3'h3;
  localparam logic [2:0] RI_RXD  = 3'h4;
  localparam logic [2:0] RI_NONE = 3'h7;

  // ****************************************
  // Timing
  // ****************************************
  localparam logic [3:0] PHASE_LAST   = 4'hF;
  localparam logic [3:0] SAMPLE_PT    = 4'h7;
  localparam logic [3:0] SYNC_BITS    = 4'h8;
  localparam logic [1:0] EXT_XFER_DLY = 2'h3;
  localparam logic [1:0] INT_XFER_DLY = 2'h2;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic pfc_tx;
    logic port_dir;
    logic port_data;
    logic stop2;
    logic par_odd;
    logic par_en;
    logic char7;
    logic ext_clk;
    logic sync_mode;
    logic re;
    logic te;
  } scp_ctrl_s;

  typedef struct packed {
    logic tx_end;
    logic per;
    logic framing_error_flag;
    logic ovr;
    logic rx_full;
    logic tx_empty;
  } scp_flag_s;

  typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} scp_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b011,
    RX_PAR   = 3'b010,
    RX_STOP  = 3'b110
  } scp_rx_e;

  typedef struct packed {
    scp_ctrl_s   ctrl;
    logic [15:0] baud;
    scp_flag_s   flags;
    logic [7:0]  thr;
    logic [7:0]  rx_holding_reg;
    logic [11:0] tx_shift_reg;
    logic [7:0]  rx_shift_reg;
    scp_tx_e     tx_st;
    scp_rx_e     rx_st;
    logic [3:0]  tx_cnt;
    logic [3:0]  tx_phase;
    logic [3:0]  rx_cnt;
    logic [3:0]  rx_phase;
    logic        rx_par;
    logic        rxd_prev;
    logic        brk;
    logic        sck_prev;
    logic        sy_act;
    logic        sy_rx;
    logic        sy_txbit;
    logic [1:0]  xfer_cnt;
    logic [15:0] div;
    logic        a_sel;
    logic        a_wr;
    logic [7:0]  a_addr;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        txd_out;
    logic        txd_oe_b;
    logic        sck_out;
    logic        sck_oe_b;
    logic        err_irq;
    logic        rx_dma_req;
    logic        tx_dma_req;
  } scp_state_s;

  // ****************************************
  // Reset values
  // ****************************************
  localparam scp_ctrl_s   CTRL_RST = 11'h000;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam scp_flag_s   FLAG_RST = 6'h21;
  localparam logic [11:0] TSR_IDLE = 12'hFFF;

  localparam scp_state_s STATE_RST = '{
    ctrl:     CTRL_RST,
    baud:     BAUD_RST,
    flags:    FLAG_RST,
    tx_shift_reg:      TSR_IDLE,
    tx_st:    TX_IDLE,
    rx_st:    RX_IDLE,
    rxd_prev: 1'b1,
    sck_prev: 1'b1,
    sy_txbit: 1'b1,
    hready:   1'b1,
    txd_oe_b: 1'b1,
    sck_out:  1'b1,
    sck_oe_b: 1'b1,
    default:  '0
  };

endpackage

// >>> verilog/scp_serial_port.sv
// Serial port with AHB-Lite register slave, async and sync engines
`timescale 1ns/100ps
module scp_serial_port (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rxd_in,
  input  wire logic        sck_in,
  output logic             txd_out,
  output logic             txd_oe_b,
  output logic             sck_out,
  output logic             sck_oe_b,
  output logic             rx_error_irq,
  output logic             rx_dma_req,
  output logic             tx_dma_req
);

  // ****************************************
  // Declarations
  // ****************************************
  scp_pkg::scp_state_s s;
  scp_pkg::scp_state_s n;
  scp_pkg::scp_flag_s  fw;
  logic [1:0]          pins_s;
  logic                rxd_s;
  logic                sck_s;
  logic                tick;
  logic [2:0]          rd_sel;
  logic [2:0]          wr_sel;
  logic                txd_wr;
  logic                err;
  logic                done;
  logic                d_fer;
  logic                d_per;
  logic [7:0]          d_data;
  logic                full_only;
  logic                rise;
  logic                fall;
  logic                sample;
  logic                last;
  logic                serial;
  logic                ser_bit;
  logic                ext;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    case (a)
      scp_pkg::CTRL_OFS: reg_sel = scp_pkg::RI_CTRL;
      scp_pkg::BAUD_OFS: reg_sel = scp_pkg::RI_BAUD;
      scp_pkg::STAT_OFS: reg_sel = scp_pkg::RI_STAT;
      scp_pkg::TXD_OFS:  reg_sel = scp_pkg::RI_TXD;
      scp_pkg::RXD_OFS:  reg_sel = scp_pkg::RI_RXD;
      default:           reg_sel = scp_pkg::RI_NONE;
    endcase
  endfunction

  // Start, data, optional parity, stop bits, LSB first
  function automatic logic [11:0] frame_of(input logic [7:0] d,
                                           input scp_pkg::scp_ctrl_s c);
    logic [11:0] f;
    logic        p;
    f = scp_pkg::TSR_IDLE;
    p = c.par_odd;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (!(c.char7 && i == 7)) begin
        f[i+1] = d[i];
        p = p ^ d[i];
      end
    end
    if (c.par_en) begin
      f[c.char7 ? 8 : 9] = p;
    end
    return f;
  endfunction

  // Frame of 9 to 12 bit periods
  function automatic logic [3:0] frame_len(input scp_pkg::scp_ctrl_s c);
    return 4'hA - {3'h0, c.char7} + {3'h0, c.par_en} + {3'h0, c.stop2};
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  scp_sync #(
    .W    (2),
    .INIT (2'h3)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .d     ({sck_in, rxd_in}),
    .q     (pins_s)
  );

  assign rxd_s = pins_s[0];
  assign sck_s = pins_s[1];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n         = s;
    ext       = s.ctrl.ext_clk;
    tick      = (s.div == 16'h0000);
    rd_sel    = reg_sel(haddr[7:0]);
    wr_sel    = reg_sel(s.a_addr);
    txd_wr    = s.a_sel & s.a_wr & (wr_sel == scp_pkg::RI_TXD);
    err       = s.flags.ovr | s.flags.framing_error_flag | s.flags.per;
    fw        = scp_pkg::scp_flag_s'(hwdata[5:0]);
    done      = 1'b0;
    d_fer     = 1'b0;
    d_per     = 1'b0;
    d_data    = s.rx_shift_reg;
    full_only = 1'b0;
    rise      = 1'b0;
    fall      = 1'b0;
    sample    = (s.rx_phase == scp_pkg::SAMPLE_PT);
    last      = (s.rx_phase == scp_pkg::PHASE_LAST);
    serial    = 1'b0;
    ser_bit   = 1'b1;

    // Base clock divider, sixteen ticks per async bit
    n.div      = tick ? s.baud : 16'(s.div - 16'h0001);
    n.sck_prev = sck_s;

    // Bus address phase, read data prepared for the data phase
    n.hready = 1'b1;
    n.hresp  = 1'b0;
    n.a_sel  = hsel & htrans[1] & hready;
    n.a_wr   = hwrite;
    n.a_addr = haddr[7:0];
    n.hrdata = 32'h0000_0000;
    if (hsel & htrans[1] & hready & ~hwrite) begin
      case (rd_sel)
        scp_pkg::RI_CTRL: n.hrdata = {21'h000000, s.ctrl};
        scp_pkg::RI_BAUD: n.hrdata = {16'h0000, s.baud};
        scp_pkg::RI_STAT: n.hrdata = {25'h0000000, rxd_s, s.flags};
        scp_pkg::RI_TXD:  n.hrdata = {24'h000000, s.thr};
        scp_pkg::RI_RXD:  n.hrdata = {24'h000000, s.rx_holding_reg};
        default:          n.hrdata = 32'h0000_0000;
      endcase
    end

    // Bus data phase writes; hardware events below override clears
    if (s.a_sel & s.a_wr) begin
      case (wr_sel)
        scp_pkg::RI_CTRL: n.ctrl = scp_pkg::scp_ctrl_s'(hwdata[10:0]);
        scp_pkg::RI_BAUD: n.baud = hwdata[15:0];
        scp_pkg::RI_STAT: begin
          n.flags.rx_full = s.flags.rx_full & fw.rx_full;
          n.flags.ovr     = s.flags.ovr & fw.ovr;
          n.flags.framing_error_flag     = s.flags.framing_error_flag & fw.framing_error_flag;
          n.flags.per     = s.flags.per & fw.per;
          n.flags.tx_end  = s.flags.tx_end & fw.tx_end;
        end
        scp_pkg::RI_TXD: begin
          n.thr            = hwdata[7:0];
          n.flags.tx_empty = 1'b0;
        end
        default: ;
      endcase
    end

    if (!s.ctrl.sync_mode) begin
      // ****************************************
      // Asynchronous transmitter
      // ****************************************
      n.sy_act = 1'b0;
      case (s.tx_st)
        scp_pkg::TX_IDLE: begin
          if (s.ctrl.te & ~s.flags.tx_empty & ~txd_wr) begin
            n.tx_shift_reg            = frame_of(s.thr, s.ctrl);
            n.tx_cnt         = frame_len(s.ctrl);
            n.tx_phase       = 4'h0;
            n.flags.tx_empty = 1'b1;
            n.flags.tx_end   = 1'b0;
            n.tx_st          = scp_pkg::TX_SHIFT;
          end
        end
        scp_pkg::TX_SHIFT: begin
          if (tick) begin
            n.tx_phase = s.tx_phase + 4'h1;
            if (s.tx_phase == scp_pkg::PHASE_LAST) begin
              n.tx_shift_reg    = {1'b1, s.tx_shift_reg[11:1]};
              n.tx_cnt = s.tx_cnt - 4'h1;
              if (s.tx_cnt == 4'h1) begin
                n.tx_st        = scp_pkg::TX_IDLE;
                n.flags.tx_end = 1'b1;
              end
            end
          end
        end
        default: n.tx_st = scp_pkg::TX_IDLE;
      endcase

      // ****************************************
      // Asynchronous receiver
      // ****************************************
      if (!s.ctrl.re) begin
        n.rx_st = scp_pkg::RX_IDLE;
      end else if (tick) begin
        n.rxd_prev = rxd_s;
        n.rx_phase = s.rx_phase + 4'h1;
        case (s.rx_st)
          scp_pkg::RX_IDLE: begin
            n.rx_phase = 4'h0;
            if (rxd_s) begin
              n.brk = 1'b0;
            end else if (s.rxd_prev | s.brk) begin
              n.rx_st    = scp_pkg::RX_START;
              n.rx_phase = 4'h1;
              n.rx_par   = s.ctrl.par_odd;
              n.rx_cnt   = 4'h0;
            end
          end
          scp_pkg::RX_START: begin
            if (sample & rxd_s) begin
              n.rx_st = scp_pkg::RX_IDLE;
            end else if (last) begin
              n.rx_st = scp_pkg::RX_DATA;
            end
          end
          scp_pkg::RX_DATA: begin
            if (sample) begin
              n.rx_shift_reg    = {rxd_s, s.rx_shift_reg[7:1]};
              n.rx_par = s.rx_par ^ rxd_s;
              n.rx_cnt = s.rx_cnt + 4'h1;
            end
            if (last & (s.rx_cnt == (s.ctrl.char7 ? 4'h7 : 4'h8))) begin
              n.rx_st = s.ctrl.par_en ? scp_pkg::RX_PAR : scp_pkg::RX_STOP;
            end
          end
          scp_pkg::RX_PAR: begin
            if (sample) begin
              n.rx_par = s.rx_par ^ rxd_s;
            end
            if (last) begin
              n.rx_st = scp_pkg::RX_STOP;
            end
          end
          scp_pkg::RX_STOP: begin
            if (sample) begin
              done    = 1'b1;
              d_fer   = ~rxd_s;
              d_per   = s.ctrl.par_en & s.rx_par;
              d_data  = s.ctrl.char7 ? {1'b0, s.rx_shift_reg[7:1]} : s.rx_shift_reg;
              n.brk   = ~rxd_s;
              n.rx_st = scp_pkg::RX_IDLE;
            end
          end
          default: n.rx_st = scp_pkg::RX_IDLE;
        endcase
      end
    end else begin
      // ****************************************
      // Synchronous engine, shared clock
      // ****************************************
      n.tx_st = scp_pkg::TX_IDLE;
      n.rx_st = scp_pkg::RX_IDLE;
      rise = ext ? (sck_s & ~s.sck_prev) : (s.sy_act & tick & ~s.sck_out);
      fall = ext ? (~sck_s & s.sck_prev) : (s.sy_act & tick & s.sck_out);
      if (!s.sy_act) begin
        n.sck_out  = 1'b1;
        n.sy_txbit = 1'b1;
        if (~err & ~txd_wr & (s.xfer_cnt == 2'h0) &
            ((s.ctrl.te & ~s.flags.tx_empty) |
             (s.ctrl.re & ~s.ctrl.te & ~s.flags.rx_full))) begin
          n.sy_act = 1'b1;
          n.sy_rx  = s.ctrl.re;
          n.tx_cnt = 4'h0;
          if (s.ctrl.te) begin
            n.tx_shift_reg            = {4'hF, s.thr};
            n.flags.tx_empty = 1'b1;
            n.flags.tx_end   = 1'b0;
          end
        end
      end else begin
        if (!ext & tick) begin
          n.sck_out = ~s.sck_out;
        end
        if (fall) begin
          n.sy_txbit = s.tx_shift_reg[0];
        end
        if (rise) begin
          n.tx_shift_reg    = {1'b1, s.tx_shift_reg[11:1]};
          n.rx_shift_reg    = {rxd_s, s.rx_shift_reg[7:1]};
          n.tx_cnt = s.tx_cnt + 4'h1;
          if (s.tx_cnt == scp_pkg::SYNC_BITS - 4'h1) begin
            n.sy_act       = 1'b0;
            n.flags.tx_end = 1'b1;
            if (s.sy_rx) begin
              n.xfer_cnt = ext ? scp_pkg::EXT_XFER_DLY : scp_pkg::INT_XFER_DLY;
            end
          end
        end
      end
    end

    // Delayed sync transfer; receive disable in the window sets rx_full only
    if (s.xfer_cnt != 2'h0) begin
      n.xfer_cnt = s.xfer_cnt - 2'h1;
      if (!s.ctrl.re) begin
        n.xfer_cnt = 2'h0;
        full_only  = 1'b1;
      end else if (s.xfer_cnt == 2'h1) begin
        done = 1'b1;
      end
    end

    // ****************************************
    // Receive completion
    // ****************************************
    if (full_only) begin
      n.flags.rx_full = 1'b1;
    end
    if (done) begin
      n.flags.framing_error_flag = n.flags.framing_error_flag | d_fer;
      n.flags.per = n.flags.per | d_per;
      if (s.flags.rx_full) begin
        n.flags.ovr     = 1'b1;
        n.flags.rx_full = 1'b1;
      end else begin
        n.rx_holding_reg = d_data;
        if (~d_fer & ~d_per & ~err) begin
          n.flags.rx_full = 1'b1;
        end
      end
    end

    // Transmit enable low resets the transmitter
    if (!s.ctrl.te) begin
      n.tx_st          = scp_pkg::TX_IDLE;
      n.tx_shift_reg            = scp_pkg::TSR_IDLE;
      n.flags.tx_empty = 1'b1;
      n.sy_txbit       = 1'b1;
      if (!s.ctrl.re) begin
        n.sy_act = 1'b0;
      end
    end

    // ****************************************
    // Pins and requests
    // ****************************************
    serial = n.ctrl.te & n.ctrl.pfc_tx;
    if (n.ctrl.sync_mode) begin
      ser_bit = n.sy_txbit;
    end else begin
      ser_bit = (n.tx_st == scp_pkg::TX_SHIFT) ? n.tx_shift_reg[0] : 1'b1;
    end
    n.txd_out    = serial ? ser_bit : n.ctrl.port_data;
    n.txd_oe_b   = serial ? 1'b0 : ~n.ctrl.port_dir;
    n.sck_oe_b   = ~(n.ctrl.sync_mode & ~n.ctrl.ext_clk);
    n.err_irq    = n.flags.ovr | n.flags.framing_error_flag | n.flags.per;
    n.rx_dma_req = n.flags.rx_full;
    n.tx_dma_req = n.flags.tx_empty & n.ctrl.te;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= scp_pkg::STATE_RST;
    end else if (ce) begin
      s <= n;
    end
  end

  assign hrdata       = s.hrdata;
  assign hreadyout    = s.hready;
  assign hresp        = s.hresp;
  assign txd_out      = s.txd_out;
  assign txd_oe_b     = s.txd_oe_b;
  assign sck_out      = s.sck_out;
  assign sck_oe_b     = s.sck_oe_b;
  assign rx_error_irq = s.err_irq;
  assign rx_dma_req   = s.rx_dma_req;
  assign tx_dma_req   = s.tx_dma_req;

endmodule

// >>> verilog/scp_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module scp_sync #(
  parameter int unsigned    W    = 1,
  parameter logic [W-1:0]   INIT = '1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [1:0][W-1:0] st;
  logic [1:0][W-1:0] next_st;

  always_comb begin
    next_st = {st[0], d};
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= {INIT, INIT};
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign q = st[1];

endmodule
